// ==== dio_port_set.sv ====
// Digital I/O port set: six 8-bit ports, one 1-bit port, input-only port 6,
// SFR access from the core. Assumes the core drives sfrAddr/sfrWr/sfrRd for
// one cycle per access and samples sfrRdData the cycle after sfrRd.
// Notes on behaviour
// - 49 lines: six 8-bit bidirectional ports plus one 1-bit port.
// - Each port bit has a storage latch, output driver and input buffer, except input-only port 6 (input buffer only).
// - Each port is read and written only through its own SFR.
// - Port 5 is quasi-bidirectional or true bidirectional by structure bit.
// - Port 0 drives low address, then write data or receives read data.
// - Port 2 drives high address on 16-bit accesses, else its latch.
// - Writes to port 6 do nothing.
// - Reading port 6 returns the levels on its input lines.
// - Analog channel is a three-bit field in either converter register.
// - Port 6 is read as one whole byte, never by bit.
// - After reset port 5 is quasi-bidirectional, structure select cleared.
// - Port 5 direction register shares the port 5 data address.
// - Direction-map select high routes port 5 address to direction register.
module dio_port_set #(
  parameter int NUM_BYTE_PORTS = 6
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic [7:0] sfrAddr,
  input wire logic [7:0] sfrWrData,
  input wire logic sfrWr,
  input wire logic sfrRd,
  input wire logic sfrBitWr,
  input wire logic [2:0] sfrBitSel,
  output logic [7:0] sfrRdData,
  output logic sfrHit,
  input wire logic extAccess,
  input wire logic extAddr16,
  input wire logic extAddrPhase,
  input wire logic extWrite,
  input wire logic [15:0] extAddr,
  input wire logic [7:0] extWrData,
  output logic [7:0] extRdData,
  input wire logic [7:0] p0PinIn,
  output logic [7:0] p0PinOut,
  output logic [7:0] p0PinOe,
  input wire logic [7:0] p1PinIn,
  output logic [7:0] p1PinOut,
  output logic [7:0] p1PinOe,
  input wire logic [7:0] p2PinIn,
  output logic [7:0] p2PinOut,
  output logic [7:0] p2PinOe,
  input wire logic [7:0] p3PinIn,
  output logic [7:0] p3PinOut,
  output logic [7:0] p3PinOe,
  input wire logic [7:0] p4PinIn,
  output logic [7:0] p4PinOut,
  output logic [7:0] p4PinOe,
  input wire logic [7:0] p5PinIn,
  output logic [7:0] p5PinOut,
  output logic [7:0] p5PinOe,
  input wire logic [7:0] p6PinIn,
  input wire logic p7PinIn,
  output logic p7PinOut,
  output logic p7PinOe,
  output logic port5StructSelect,
  output logic [2:0] analogChannel
);
  localparam int W = dio_pkg::PORT_W;

  initial begin
    if (NUM_BYTE_PORTS != 6) $error("dio_port_set: six byte ports only");
  end

  // Latches of ports 0..5 (index = port number)
  logic [7:0] latch_ff [6];
  logic [7:0] port5_direction_reg_ff;
  logic [7:0] sysCtl_ff;
  logic [7:0] iprioB_ff;
  logic [7:0] convA_ff;
  logic [7:0] convB_ff;
  logic p7Latch_ff;
  logic [7:0] pinSync [6];
  logic [7:0] p6Sync;
  logic p7Sync;
  logic [7:0] pinRaw [6];
  logic [5:0] portHit;
  logic [7:0] nxtSfrRdData;
  logic nxtSfrHit;
  logic dirMap;
  logic [7:0] wrVal [6];

  assign pinRaw[0] = p0PinIn;
  assign pinRaw[1] = p1PinIn;
  assign pinRaw[2] = p2PinIn;
  assign pinRaw[3] = p3PinIn;
  assign pinRaw[4] = p4PinIn;
  assign pinRaw[5] = p5PinIn;

  assign dirMap = iprioB_ff[dio_pkg::IPRIO_DIRMAP_BIT];
  assign portHit[0] = (sfrAddr == dio_pkg::ADDR_PORT0);
  assign portHit[1] = (sfrAddr == dio_pkg::ADDR_PORT1);
  assign portHit[2] = (sfrAddr == dio_pkg::ADDR_PORT2);
  assign portHit[3] = (sfrAddr == dio_pkg::ADDR_PORT3);
  assign portHit[4] = (sfrAddr == dio_pkg::ADDR_PORT4);
  // Port 5 data is hidden while the direction map is selected
  assign portHit[5] = (sfrAddr == dio_pkg::ADDR_PORT5) && !dirMap;

  // Input buffers: every pin passes two flops before any read
  genvar gi;
  generate
    for (gi = 0; gi < 6; gi++) begin : g_port
      dio_sync #(.WIDTH(W)) u_sync (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .pinIn(pinRaw[gi]),
        .pinSync(pinSync[gi])
      );

      // Bit writes touch one bit; byte writes replace the latch
      always_comb begin
        wrVal[gi] = latch_ff[gi];
        if (sfrBitWr) begin
          wrVal[gi][sfrBitSel] = sfrWrData[0];
        end else begin
          wrVal[gi] = sfrWrData;
        end
      end

      always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
          latch_ff[gi] <= dio_pkg::RST_PORT;
        end else if ((sfrWr || sfrBitWr) && portHit[gi]) begin
          latch_ff[gi] <= wrVal[gi];
        end
      end
    end
  endgenerate

  dio_sync #(.WIDTH(W)) u_sync6 (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .pinIn(p6PinIn),
    .pinSync(p6Sync)
  );

  dio_sync #(.WIDTH(1)) u_sync7 (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .pinIn(p7PinIn),
    .pinSync(p7Sync)
  );

  // Direction register at the port 5 address
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      port5_direction_reg_ff <= dio_pkg::RST_PORT5_DIRECTION_REG;
    end else if (sfrWr && dirMap && sfrAddr == dio_pkg::ADDR_PORT5) begin
      port5_direction_reg_ff <= sfrWrData;
    end else if (sfrBitWr && dirMap && sfrAddr == dio_pkg::ADDR_PORT5) begin
      port5_direction_reg_ff[sfrBitSel] <= sfrWrData[0];
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      sysCtl_ff <= dio_pkg::RST_SYSCTL;
    end else if (sfrWr && sfrAddr == dio_pkg::ADDR_SYSCTL) begin
      sysCtl_ff <= sfrWrData;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      iprioB_ff <= dio_pkg::RST_IPRIO_B;
    end else if (sfrWr && sfrAddr == dio_pkg::ADDR_IPRIO_B) begin
      iprioB_ff <= sfrWrData;
    end
  end

  // Both converter registers hold the same channel field
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      convA_ff <= dio_pkg::RST_CONV;
      convB_ff <= dio_pkg::RST_CONV;
    end else if (sfrWr && sfrAddr == dio_pkg::ADDR_CONV_A) begin
      convA_ff <= sfrWrData;
      convB_ff[2:0] <= sfrWrData[2:0];
    end else if (sfrWr && sfrAddr == dio_pkg::ADDR_CONV_B) begin
      convB_ff <= {sfrWrData[7], 4'h0, sfrWrData[2:0]};
      convA_ff[2:0] <= sfrWrData[2:0];
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      p7Latch_ff <= dio_pkg::RST_PORT7;
    end else if (sfrWr && sfrAddr == dio_pkg::ADDR_PORT7) begin
      p7Latch_ff <= sfrWrData[0];
    end else if (sfrBitWr && sfrAddr == dio_pkg::ADDR_PORT7
                 && sfrBitSel == 3'h0) begin
      p7Latch_ff <= sfrWrData[0];
    end
  end

  // Read mux; port reads return pin levels, port 6 whole byte
  always_comb begin
    nxtSfrRdData = 8'h00;
    nxtSfrHit = 1'b1;
    case (sfrAddr)
      dio_pkg::ADDR_PORT0: nxtSfrRdData = pinSync[0];
      dio_pkg::ADDR_PORT1: nxtSfrRdData = pinSync[1];
      dio_pkg::ADDR_PORT2: nxtSfrRdData = pinSync[2];
      dio_pkg::ADDR_PORT3: nxtSfrRdData = pinSync[3];
      dio_pkg::ADDR_PORT4: nxtSfrRdData = pinSync[4];
      dio_pkg::ADDR_PORT5: begin
        nxtSfrRdData = dirMap ? port5_direction_reg_ff : pinSync[5];
      end
      dio_pkg::ADDR_PORT6: nxtSfrRdData = p6Sync;
      dio_pkg::ADDR_PORT7: nxtSfrRdData = {7'h00, p7Sync};
      dio_pkg::ADDR_SYSCTL: nxtSfrRdData = sysCtl_ff;
      dio_pkg::ADDR_IPRIO_B: nxtSfrRdData = iprioB_ff;
      dio_pkg::ADDR_CONV_A: nxtSfrRdData = convA_ff;
      dio_pkg::ADDR_CONV_B: nxtSfrRdData = convB_ff;
      default: nxtSfrHit = 1'b0;
    endcase
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      sfrRdData <= 8'h00;
      sfrHit <= 1'b0;
    end else begin
      sfrRdData <= sfrRd ? nxtSfrRdData : 8'h00;
      sfrHit <= sfrRd && nxtSfrHit;
    end
  end

  // Port 0: address, then data during external accesses
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      p0PinOut <= 8'h00;
      p0PinOe <= 8'h00;
      extRdData <= 8'h00;
    end else if (extAccess) begin
      if (extAddrPhase) begin
        p0PinOut <= extAddr[7:0];
        p0PinOe <= 8'hFF;
      end else if (extWrite) begin
        p0PinOut <= extWrData;
        p0PinOe <= 8'hFF;
      end else begin
        p0PinOe <= 8'h00;
        extRdData <= pinSync[0];
      end
    end else begin
      // Open-drain: only a zero in the latch drives the pin
      p0PinOut <= 8'h00;
      p0PinOe <= ~latch_ff[0];
    end
  end

  // Port 2: high address on 16-bit accesses, else latch
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      p2PinOut <= 8'hFF;
      p2PinOe <= 8'hFF;
    end else if (extAccess && extAddr16) begin
      p2PinOut <= extAddr[15:8];
      p2PinOe <= 8'hFF;
    end else begin
      p2PinOut <= latch_ff[2];
      p2PinOe <= 8'hFF;
    end
  end

  // Quasi-bidirectional ports leave a one to the weak pull-up; only a zero in the latch drives the pin
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      p1PinOut <= 8'hFF;
      p3PinOut <= 8'hFF;
      p4PinOut <= 8'hFF;
      p1PinOe <= 8'h00;
      p3PinOe <= 8'h00;
      p4PinOe <= 8'h00;
      p7PinOut <= 1'b1;
      p7PinOe <= 1'b0;
    end else begin
      p1PinOut <= latch_ff[1];
      p3PinOut <= latch_ff[3];
      p4PinOut <= latch_ff[4];
      p1PinOe <= ~latch_ff[1];
      p3PinOe <= ~latch_ff[3];
      p4PinOe <= ~latch_ff[4];
      p7PinOut <= p7Latch_ff;
      p7PinOe <= ~p7Latch_ff;
    end
  end

  // Port 5 structure select: quasi-bidir or true bidir
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      p5PinOut <= 8'hFF;
      p5PinOe <= 8'h00;
      port5StructSelect <= 1'b0;
    end else begin
      port5StructSelect <= sysCtl_ff[dio_pkg::SYSCTL_STRUCT_BIT];
      p5PinOut <= latch_ff[5];
      if (sysCtl_ff[dio_pkg::SYSCTL_STRUCT_BIT]) begin
        p5PinOe <= ~port5_direction_reg_ff;
      end else begin
        p5PinOe <= ~latch_ff[5];
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      analogChannel <= 3'h0;
    end else begin
      analogChannel <= convA_ff[2:0];
    end
  end
endmodule : dio_port_set

// ==== dio_pkg.sv ====
// Package for the digital I/O port set: SFR addresses, field positions,
// reset values. Assumes an 8-bit SFR bus driven by the core on ref_clk.
package dio_pkg;
  localparam int PORT_W = 8;
  localparam logic [7:0] ADDR_PORT0 = 8'h80;
  localparam logic [7:0] ADDR_PORT1 = 8'h90;
  localparam logic [7:0] ADDR_PORT2 = 8'hA0;
  localparam logic [7:0] ADDR_PORT3 = 8'hB0;
  localparam logic [7:0] ADDR_PORT4 = 8'hE8;
  localparam logic [7:0] ADDR_PORT5 = 8'hF8;
  localparam logic [7:0] ADDR_PORT6 = 8'hDB;
  localparam logic [7:0] ADDR_PORT7 = 8'hFA;
  localparam logic [7:0] ADDR_SYSCTL = 8'hB1;
  localparam logic [7:0] ADDR_IPRIO_B = 8'hB9;
  localparam logic [7:0] ADDR_CONV_A = 8'hD8;
  localparam logic [7:0] ADDR_CONV_B = 8'hDC;
  localparam int SYSCTL_STRUCT_BIT = 6;
  localparam int IPRIO_DIRMAP_BIT = 7;
  localparam int CONV_CHAN_LSB = 0;
  localparam int CONV_CHAN_W = 3;
  localparam int CONV_B_ADCL_BIT = 7;
  localparam logic [7:0] RST_PORT = 8'hFF;
  localparam logic [7:0] RST_PORT5_DIRECTION_REG = 8'hFF;
  localparam logic [7:0] RST_SYSCTL = 8'h21;
  localparam logic [7:0] RST_IPRIO_B = 8'h00;
  localparam logic [7:0] RST_CONV = 8'h00;
  localparam logic RST_PORT7 = 1'b1;
  localparam int SYNC_STAGES = 2;
endpackage : dio_pkg

// ==== dio_sync.sv ====
// Two-flop synchroniser for a bus of pin inputs.
// Assumes pins are asynchronous to ref_clk.
module dio_sync #(
  parameter int WIDTH = 8
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic [WIDTH-1:0] pinIn,
  output logic [WIDTH-1:0] pinSync
);
  logic [WIDTH-1:0] stage1_ff;

  initial begin
    if (WIDTH < 1) $error("dio_sync: WIDTH must be positive");
  end

  // First stage feeds only the second stage
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      stage1_ff <= '0;
      pinSync <= '0;
    end else begin
      stage1_ff <= pinIn;
      pinSync <= stage1_ff;
    end
  end
endmodule : dio_sync

// ==== dio_port_set_props.sv ====
// Checker for the digital I/O port set, bound to its top module.
// Assumes one clock domain, ref_clk, with async reset rst_n.
module dio_port_set_props (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic [7:0] sfrAddr,
  input wire logic [7:0] sfrWrData,
  input wire logic sfrWr,
  input wire logic sfrRd,
  input wire logic [7:0] sfrRdData,
  input wire logic sfrHit,
  input wire logic extAccess,
  input wire logic extAddr16,
  input wire logic extAddrPhase,
  input wire logic extWrite,
  input wire logic [15:0] extAddr,
  input wire logic [7:0] extWrData,
  input wire logic [7:0] p0PinOut,
  input wire logic [7:0] p0PinOe,
  input wire logic [7:0] p2PinOut,
  input wire logic [7:0] p2PinOe,
  input wire logic [7:0] p5PinOut,
  input wire logic [7:0] p5PinOe,
  input wire logic port5StructSelect,
  input wire logic [2:0] analogChannel
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  // Phases held two cycles, so one cycle of output latency is absorbed
  sequence addrHeld;
    (extAccess && extAddrPhase) [*2] ##0 $stable(extAddr);
  endsequence
  sequence acc16;
    (extAccess && extAddr16) [*2] ##0 $stable(extAddr);
  endsequence
  sequence dataHeld(logic w);
    (extAccess && !extAddrPhase && extWrite == w) [*2] ##0 $stable(extWrData);
  endsequence
  a_p0_low_addr: assert property (addrHeld |-> p0PinOut == extAddr[7:0])
    else $error("port 0 does not show the low address byte");
  a_p0_wr_data: assert property (dataHeld(1'b1) |->
    p0PinOut == extWrData)
    else $error("port 0 does not show the write data");
  a_p0_rd_release: assert property (dataHeld(1'b0) |-> p0PinOe == 8'h00)
    else $error("port 0 still drives during a read");
  a_p2_high_addr: assert property (acc16 |-> p2PinOut == extAddr[15:8])
    else $error("port 2 does not show the high address byte");
  a_struct_reset: assert property ($rose(rst_n) |-> !port5StructSelect)
    else $error("structure select set after reset");
  // The select output trails the register by one more flop
  a_struct_write: assert property (
    sfrWr && sfrAddr == dio_pkg::ADDR_SYSCTL |=> ##1
    port5StructSelect == $past(sfrWrData[dio_pkg::SYSCTL_STRUCT_BIT], 2))
    else $error("structure select does not follow its write");
  a_quasi_oe: assert property (!port5StructSelect && !$past(port5StructSelect)
    |-> p5PinOe == ~p5PinOut)
    else $error("quasi port 5 drives a high level");
  a_chan_write: assert property (sfrWr && (sfrAddr == 8'hD8 ||
    sfrAddr == 8'hDC) |=> ##1 analogChannel == $past(sfrWrData[2:0], 2))
    else $error("channel field does not follow its write");
  a_unmapped_zero: assert property (sfrRd && sfrAddr == 8'h00 |=>
    sfrRdData == 8'h00 && !sfrHit)
    else $error("unmapped read answered");
  a_p6_read_hit: assert property (sfrRd && sfrAddr == 8'hDB |=> sfrHit)
    else $error("port 6 byte read not answered");
endmodule : dio_port_set_props

// ==== dio_pin_model.sv ====
// Far side of one port: resolves each line from both drivers.
// Assumes a weak pull-up on every line, as on quasi-bidirectional pins.
module dio_pin_model #(
  parameter int W = 8
) (
  input wire logic [W-1:0] pinOut,
  input wire logic [W-1:0] pinOe,
  input wire logic [W-1:0] farData,
  input wire logic [W-1:0] farOe,
  output logic [W-1:0] pinIn
);
  timeunit 1ns;
  timeprecision 1ns;
  // A released line goes to the pull-up, never keeps its last value
  always_comb begin
    for (int b = 0; b < W; b++) begin
      pinIn[b] = pinOe[b] ? pinOut[b] : (farOe[b] ? farData[b] : 1'b1);
    end
  end
endmodule : dio_pin_model

// ==== dio_port_set_test.sv ====
// Testbench for the digital I/O port set: SFR tasks and pin models.
// Assumes read data one cycle after sfrRd and two-flop pin synchronisers.
module dio_port_set_test;
  timeunit 1ns;
  timeprecision 1ns;
  logic ref_clk = 1'b0, rst_n = 1'b0, sfrWr = 1'b0, sfrRd = 1'b0, sfrHit;
  logic extAccess = 1'b0, extAddr16 = 1'b0, extAddrPhase = 1'b0;
  logic extWrite = 1'b0, p7PinOut, p7PinOe, port5StructSelect;
  logic [7:0] sfrAddr = 8'h00, sfrWrData = 8'h00, p6PinIn = 8'h00;
  logic [7:0] sfrRdData, extRdData, p0PinIn, p0PinOut, p0PinOe, p1PinIn;
  logic [7:0] p1PinOut, p1PinOe, p2PinOut, p2PinOe, p3PinOut, p3PinOe;
  logic [7:0] p4PinOut, p4PinOe, p5PinIn, p5PinOut, p5PinOe;
  logic [7:0] farD0 = 8'h00, farE0 = 8'h00, farD5 = 8'h00, farE5 = 8'h00;
  logic [7:0] extWrData = 8'h00;
  logic sfrBitWr = 1'b0;
  logic [2:0] sfrBitSel = 3'h0;
  logic [15:0] extAddr = 16'h0000;
  logic [2:0] analogChannel;
  int fails = 0, cmp_count = 0;
  // Idle ports loop back on themselves so their input paths still run
  dio_port_set dio_port_set_i (.*,
    .p2PinIn(p2PinOut), .p3PinIn(p3PinOut), .p4PinIn(p4PinOut),
    .p7PinIn(p7PinOut));
  dio_pin_model p0Pins (.pinOut(p0PinOut), .pinOe(p0PinOe), .farData(farD0),
    .farOe(farE0), .pinIn(p0PinIn));
  dio_pin_model p1Pins (.pinOut(p1PinOut), .pinOe(p1PinOe), .farData(8'h00),
    .farOe(8'h00), .pinIn(p1PinIn));
  dio_pin_model p5Pins (.pinOut(p5PinOut), .pinOe(p5PinOe), .farData(farD5),
    .farOe(farE5), .pinIn(p5PinIn));
  initial begin
    forever #10 ref_clk = ~ref_clk;
  end
  task automatic w(input int n);
    repeat (n) @(negedge ref_clk);
  endtask : w
  task automatic chk(input string what, input logic [7:0] e, logic [7:0] g);
    cmp_count++;
    if (g !== e) begin
      fails++;
      $display("mismatch %s expected %h seen %h", what, e, g);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    w(1);
    sfrAddr = a;
    sfrWrData = d;
    sfrWr = 1'b1;
    w(1);
    sfrWr = 1'b0;
  endtask : wr
  task automatic rdc(input logic [7:0] a, input logic [7:0] e, string what);
    w(1);
    sfrAddr = a;
    sfrRd = 1'b1;
    w(1);
    sfrRd = 1'b0;
    chk(what, e, sfrRdData);
    chk("hit", {7'h00, a != 8'h00}, {7'h00, sfrHit});
  endtask : rdc
  task automatic bwr(input logic [7:0] a, input logic [2:0] b, input logic v);
    w(1);
    sfrAddr = a;
    sfrBitSel = b;
    sfrWrData = {7'h00, v};
    sfrBitWr = 1'b1;
    w(1);
    sfrBitWr = 1'b0;
  endtask : bwr
  task automatic wrap_up;
    $display("compares %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : wrap_up
  initial begin
    #20000;
    fails++;
    wrap_up;
  end
  initial begin
    w(8);
    rst_n = 1'b1;
    chk("p5 oe", 8'h00, p5PinOe);
    chk("struct", 8'h00, {7'h00, port5StructSelect});
    chk("p2 out", 8'hFF, p2PinOut);
    chk("p2 oe", 8'hFF, p2PinOe);
    chk("p7", 8'h01, {6'h00, p7PinOe, p7PinOut});
    wr(8'h90, 8'h5A);
    w(4);
    chk("p1 oe", 8'hA5, p1PinOe);
    rdc(8'h90, 8'h5A, "p1 pins");
    p6PinIn = 8'h3C;
    w(4);
    rdc(8'hDB, 8'h3C, "p6 pins");
    wr(8'hDB, 8'h00);
    rdc(8'hDB, 8'h3C, "p6 after write");
    rdc(8'h00, 8'h00, "unmapped");
    bwr(8'h90, 3'h0, 1'b1);
    bwr(8'hDB, 3'h1, 1'b0);
    wr(8'hE8, 8'hC3);
    wr(8'hFA, 8'h00);
    w(4);
    chk("p4 oe", 8'h3C, p4PinOe);
    chk("p3 oe", 8'h00, p3PinOe);
    rdc(8'h90, 8'h5B, "p1 bit write");
    rdc(8'hDB, 8'h3C, "p6 bit write");
    rdc(8'hE8, 8'hC3, "p4 pins");
    rdc(8'hB0, 8'hFF, "p3 pins");
    rdc(8'hFA, 8'h00, "p7 pin");
    chk("p7 oe", 8'h01, {7'h00, p7PinOe});
    wr(8'hF8, 8'h0F);
    w(2);
    chk("p5 quasi oe", 8'hF0, p5PinOe);
    wr(8'hB1, 8'h61);
    wr(8'hB9, 8'h80);
    wr(8'hF8, 8'hF0);
    wr(8'hB9, 8'h00);
    w(2);
    chk("p5 data kept", 8'h0F, p5PinOut);
    wr(8'hF8, 8'hA5);
    farD5 = 8'h60;
    farE5 = 8'hFF;
    w(4);
    chk("struct", 8'h01, {7'h00, port5StructSelect});
    chk("p5 dir oe", 8'h0F, p5PinOe);
    chk("p5 out", 8'hA5, p5PinOut);
    rdc(8'hF8, 8'h65, "p5 pins");
    for (int i = 0; i < 8; i++) begin
      wr(i[0] ? 8'hDC : 8'hD8, {5'h00, i[2:0]});
      w(1);
      chk("chan", {5'h00, i[2:0]}, {5'h00, analogChannel});
    end
    // Channel 7 is analog now; port 6 still returns bit 7, so the check masks it off
    p6PinIn = 8'hBC;
    w(3);
    sfrAddr = 8'hDB;
    sfrRd = 1'b1;
    w(1);
    sfrRd = 1'b0;
    chk("p6 masked", 8'h3C, sfrRdData & 8'h7F);
    wr(8'hA0, 8'h3C);
    extAccess = 1'b1;
    extAddr16 = 1'b1;
    extAddrPhase = 1'b1;
    extAddr = 16'h1234;
    w(3);
    chk("p0 addr", 8'h34, p0PinOut);
    chk("p2 addr", 8'h12, p2PinOut);
    extAddrPhase = 1'b0;
    extWrite = 1'b1;
    extWrData = 8'h9C;
    w(3);
    chk("p0 wdata", 8'h9C, p0PinOut);
    extWrite = 1'b0;
    farD0 = 8'hE7;
    farE0 = 8'hFF;
    w(4);
    chk("p0 rdata", 8'hE7, extRdData);
    extAddr16 = 1'b0;
    w(3);
    chk("p2 latch", 8'h3C, p2PinOut);
    extAccess = 1'b0;
    farE0 = 8'h00;
    w(2);
    chk("p0 oe idle", 8'h00, p0PinOe);
    rst_n = 1'b0;
    w(2);
    rst_n = 1'b1;
    chk("struct reset", 8'h00, {7'h00, port5StructSelect});
    rdc(8'hB1, dio_pkg::RST_SYSCTL, "sysctl reset");
    wr(8'hF8, 8'h00);
    wr(8'hB1, 8'h40);
    w(2);
    chk("p5 dir reset", 8'h00, p5PinOe);
    wrap_up;
  end
endmodule : dio_port_set_test
bind dio_port_set dio_port_set_props dio_port_set_props_i (.*);
